// file: include/msg_consts.vh
/*
 Message handler constants: message codes, identify fields, sense codes,
 phase codes and action codes shared by the message handler files.
 Assumes inclusion by bare name from the rtl files.
*/
`ifndef MSG_CONSTS_VH
`define MSG_CONSTS_VH

// ---------------------------------------------------------------
// Message codes
// ---------------------------------------------------------------
`define MSG_CMD_COMPLETE 8'h00
`define MSG_EXTENDED 8'h01
`define MSG_SAVE_PTR 8'h02
`define MSG_RESTORE_PTR 8'h03
`define MSG_DISCONNECT 8'h04
`define MSG_INIT_ERR 8'h05
`define MSG_ABORT 8'h06
`define MSG_REJECT 8'h07
`define MSG_NOP 8'h08
`define MSG_PARITY_ERR 8'h09
`define MSG_DEV_RESET 8'h0C
`define MSG_IDENTIFY 8'h80

// ---------------------------------------------------------------
// Identify fields
// ---------------------------------------------------------------
`define ID_FLAG_BIT 7
`define ID_DISC_BIT 6
`define ID_RSVD_HI 5
`define ID_RSVD_LO 3
`define ID_LUN_HI 2
`define ID_LUN_LO 0
`define ID_LUN_MAX 3'h3

// ---------------------------------------------------------------
// Sense keys and codes
// ---------------------------------------------------------------
`define SENSE_KEY_NONE 4'h0
`define SENSE_KEY_ABORTED 4'hB
`define SENSE_CODE_NONE 8'h00
`define SENSE_CODE_INIT_ERR 8'h48
`define SENSE_CODE_PARITY 8'h47
`define SENSE_CODE_REJECT 8'h43

// ---------------------------------------------------------------
// Bus phases as seen by the handler
// ---------------------------------------------------------------
`define PH_DATA_OUT 3'h0
`define PH_DATA_IN 3'h1
`define PH_COMMAND 3'h2
`define PH_STATUS 3'h3
`define PH_MSG_OUT 3'h6
`define PH_MSG_IN 3'h7

// ---------------------------------------------------------------
// Actions reported to the phase sequencer
// ---------------------------------------------------------------
`define ACT_NONE 4'h0
`define ACT_BUS_FREE 4'h1
`define ACT_SEND_MSG 4'h2
`define ACT_CHECK_COND 4'h3
`define ACT_RESEND_OUT 4'h4
`define ACT_STOP_DISC 4'h5
`define ACT_STOP_RETRY 4'h6
`define ACT_IDENT_OK 4'h7
`define ACT_DEV_RESET 4'h8

// ---------------------------------------------------------------
// Retry limit default
// ---------------------------------------------------------------
`define RETRY_LIMIT_DEF 3

`endif

// file: rtl/msg_handler.v
/*
 Message handler of a bus target: interprets single-byte messages
 received in MESSAGE OUT, handles rejects of its own messages and
 runs parity recovery in the message phases.
 Assumes a phase sequencer that delivers each received message byte with
 a one-cycle strobe on clk, tells which message the target sent last, and
 carries out the action code this block issues.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msg_consts.vh"

module msg_handler #(
   parameter RETRY_LIMIT = `RETRY_LIMIT_DEF
) (
   input wire clk,
   input wire reset,
   input wire msg_valid,
   input wire [7:0] msg_byte,
   input wire msg_parity_bad,
   input wire atn_pin,
   input wire parity_enable,
   input wire [2:0] phase,
   input wire [7:0] last_sent,
   input wire reconnecting,
   input wire cmd_complete_done,
   input wire msg_in_sent,
   output reg [3:0] action,
   output reg action_valid,
   output reg [7:0] out_msg,
   output reg busy_release,
   output reg [3:0] sense_key,
   output reg [7:0] sense_code,
   output reg sense_valid,
   output reg disc_allowed,
   output reg [2:0] lun,
   output reg lun_valid,
   output reg clear_pending,
   output reg await_atn_drop
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function is_identify;
      input [7:0] b;
      begin
         is_identify = b[`ID_FLAG_BIT];
      end
   endfunction

   function identify_ok;
      input [7:0] b;
      begin
         identify_ok = (b[`ID_RSVD_HI:`ID_RSVD_LO] == 3'h0) &&
            (b[`ID_LUN_HI:`ID_LUN_LO] <= `ID_LUN_MAX);
      end
   endfunction

   // ------------------------------------------------------------
   // Pin synchronising
   // ------------------------------------------------------------
   wire atn;

   pin_sync #(
      .WIDTH(1)
   ) u_atn_sync (
      .clk(clk),
      .reset(reset),
      .din(atn_pin),
      .dout(atn)
   );

   // ------------------------------------------------------------
   // Retry counting
   // ------------------------------------------------------------
   reg retry_clear;
   reg retry_bump;
   wire retry_exhausted;
   reg [7:0] retried_msg;

   retry_counter #(
      .LIMIT(RETRY_LIMIT)
   ) u_retry (
      .clk(clk),
      .reset(reset),
      .clear(retry_clear),
      .bump(retry_bump),
      .exhausted(retry_exhausted)
   );

   // ------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_DRAIN = 2'h1;
   localparam ST_REJECT = 2'h2;
   localparam ST_LIMIT = 2'h3;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [3:0] next_action;
   reg next_action_valid;
   reg [7:0] next_out_msg;
   reg next_busy_release;
   reg [3:0] next_sense_key;
   reg [7:0] next_sense_code;
   reg next_sense_valid;
   reg next_disc_allowed;
   reg [2:0] next_lun;
   reg next_lun_valid;
   reg next_clear_pending;
   reg next_await;

   // Parity handling is gated so a disabled check never retries
   wire bad_byte = msg_valid && msg_parity_bad && parity_enable;

   always @* begin
      next_state = state;
      next_action = `ACT_NONE;
      next_action_valid = 1'b0;
      next_out_msg = out_msg;
      next_busy_release = 1'b0;
      next_sense_key = sense_key;
      next_sense_code = sense_code;
      next_sense_valid = sense_valid;
      next_disc_allowed = disc_allowed;
      next_lun = lun;
      next_lun_valid = lun_valid;
      next_clear_pending = 1'b0;
      next_await = await_atn_drop;
      retry_clear = 1'b0;
      retry_bump = 1'b0;
      case (state)
         ST_IDLE: begin
            if (cmd_complete_done) begin
               next_busy_release = 1'b1;
               next_action = `ACT_BUS_FREE;
               next_action_valid = 1'b1;
            end else if (bad_byte) begin
               // Keep taking bytes until attention falls
               next_state = ST_DRAIN;
               next_await = 1'b1;
            end else if (msg_valid) begin
               if (is_identify(msg_byte)) begin
                  if (identify_ok(msg_byte)) begin
                     next_disc_allowed = msg_byte[`ID_DISC_BIT];
                     next_lun = msg_byte[`ID_LUN_HI:`ID_LUN_LO];
                     next_lun_valid = 1'b1;
                     next_action = `ACT_IDENT_OK;
                     next_action_valid = 1'b1;
                  end else begin
                     next_state = ST_REJECT;
                  end
               end else begin
                  case (msg_byte)
                     `MSG_INIT_ERR: begin
                        if (phase == `PH_STATUS || phase == `PH_MSG_IN ||
                           phase == `PH_MSG_OUT) begin
                           next_out_msg = `MSG_RESTORE_PTR;
                           next_action = `ACT_SEND_MSG;
                           next_action_valid = 1'b1;
                        end else if (phase == `PH_DATA_IN) begin
                           next_sense_key = `SENSE_KEY_ABORTED;
                           next_sense_code = `SENSE_CODE_INIT_ERR;
                           next_sense_valid = 1'b1;
                           next_action = `ACT_CHECK_COND;
                           next_action_valid = 1'b1;
                        end else begin
                           next_state = ST_REJECT;
                        end
                     end
                     `MSG_ABORT: begin
                        next_clear_pending = 1'b1;
                        next_busy_release = 1'b1;
                        next_action = `ACT_BUS_FREE;
                        next_action_valid = 1'b1;
                     end
                     `MSG_NOP: begin
                        next_state = ST_IDLE;
                     end
                     `MSG_DEV_RESET: begin
                        next_clear_pending = 1'b1;
                        next_busy_release = 1'b1;
                        next_sense_key = `SENSE_KEY_NONE;
                        next_sense_code = `SENSE_CODE_NONE;
                        next_sense_valid = 1'b0;
                        next_disc_allowed = 1'b0;
                        next_lun = 3'h0;
                        next_lun_valid = 1'b0;
                        next_out_msg = 8'h00;
                        next_await = 1'b0;
                        retry_clear = 1'b1;
                        next_action = `ACT_DEV_RESET;
                        next_action_valid = 1'b1;
                     end
                     `MSG_PARITY_ERR: begin
                        if (!parity_enable) begin
                           next_state = ST_REJECT;
                        end else if (retry_exhausted &&
                           retried_msg == last_sent) begin
                           next_state = ST_LIMIT;
                        end else begin
                           retry_clear = (retried_msg != last_sent);
                           retry_bump = 1'b1;
                           next_out_msg = last_sent;
                           next_action = `ACT_SEND_MSG;
                           next_action_valid = 1'b1;
                        end
                     end
                     `MSG_REJECT: begin
                        case (last_sent)
                           `MSG_CMD_COMPLETE: begin
                              next_busy_release = 1'b1;
                              next_action = `ACT_BUS_FREE;
                              next_action_valid = 1'b1;
                           end
                           `MSG_DISCONNECT, `MSG_SAVE_PTR: begin
                              next_action = `ACT_STOP_DISC;
                              next_action_valid = 1'b1;
                           end
                           `MSG_RESTORE_PTR: begin
                              next_action = `ACT_STOP_RETRY;
                              next_action_valid = 1'b1;
                           end
                           `MSG_REJECT: begin
                              next_sense_key = `SENSE_KEY_ABORTED;
                              next_sense_code = `SENSE_CODE_REJECT;
                              next_sense_valid = 1'b1;
                              next_busy_release = 1'b1;
                              next_action = `ACT_BUS_FREE;
                              next_action_valid = 1'b1;
                           end
                           default: begin
                              if (is_identify(last_sent) && reconnecting) begin
                                 next_sense_key = `SENSE_KEY_ABORTED;
                                 next_sense_code = `SENSE_CODE_REJECT;
                                 next_sense_valid = 1'b1;
                                 next_busy_release = 1'b1;
                                 next_action = `ACT_BUS_FREE;
                                 next_action_valid = 1'b1;
                              end else begin
                                 next_state = ST_IDLE;
                              end
                           end
                        endcase
                     end
                     default: begin
                        // Extended and target-only codes make no sense here
                        next_state = ST_REJECT;
                     end
                  endcase
               end
            end
         end
         ST_DRAIN: begin
            // Whole garbled message consumed once attention drops
            if (!atn) begin
               next_await = 1'b0;
               if (retry_exhausted) begin
                  next_state = ST_LIMIT;
               end else begin
                  retry_bump = 1'b1;
                  next_action = `ACT_RESEND_OUT;
                  next_action_valid = 1'b1;
                  next_state = ST_IDLE;
               end
            end
         end
         ST_REJECT: begin
            // Reject goes out in message in before more bytes are taken
            next_out_msg = `MSG_REJECT;
            next_action = `ACT_SEND_MSG;
            next_action_valid = 1'b1;
            next_state = ST_IDLE;
         end
         ST_LIMIT: begin
            next_sense_key = `SENSE_KEY_ABORTED;
            next_sense_code = `SENSE_CODE_PARITY;
            next_sense_valid = 1'b1;
            next_busy_release = 1'b1;
            next_action = `ACT_BUS_FREE;
            next_action_valid = 1'b1;
            retry_clear = 1'b1;
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // A good message in leaves the retry run as it is: msg_in_sent never sets retry_clear
      if (msg_in_sent && state == ST_IDLE && !msg_valid) begin
         retry_clear = retry_clear || 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         action <= `ACT_NONE;
         action_valid <= 1'b0;
         out_msg <= 8'h00;
         busy_release <= 1'b0;
         sense_key <= `SENSE_KEY_NONE;
         sense_code <= `SENSE_CODE_NONE;
         sense_valid <= 1'b0;
         disc_allowed <= 1'b0;
         lun <= 3'h0;
         lun_valid <= 1'b0;
         clear_pending <= 1'b0;
         await_atn_drop <= 1'b0;
         retried_msg <= 8'h00;
      end else begin
         state <= next_state;
         action <= next_action;
         action_valid <= next_action_valid;
         out_msg <= next_out_msg;
         busy_release <= next_busy_release;
         sense_key <= next_sense_key;
         sense_code <= next_sense_code;
         sense_valid <= next_sense_valid;
         disc_allowed <= next_disc_allowed;
         lun <= next_lun;
         lun_valid <= next_lun_valid;
         clear_pending <= next_clear_pending;
         await_atn_drop <= next_await;
         if (retry_bump) begin
            retried_msg <= last_sent;
         end
      end
   end
endmodule // msg_handler

`default_nettype wire

// file: rtl/pin_sync.v
/*
 Three-stage synchroniser for pin-level inputs.
 Assumes one clock; output follows once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire reset,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer i;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         // Per bit: change counts only once two later stages agree
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
               dout[i] <= stage3[i];
            end
         end
      end
   end
endmodule // pin_sync

`default_nettype wire

// file: rtl/retry_counter.v
/*
 Retry counter for parity recovery of one message.
 Assumes clear is pulsed whenever a new message starts being retried.
*/
`timescale 1ns/1ps
`default_nettype none

module retry_counter #(
   parameter LIMIT = 3
) (
   input wire clk,
   input wire reset,
   input wire clear,
   input wire bump,
   output reg exhausted
);
   localparam [3:0] LAST = LIMIT[3:0] - 4'h1;
   reg [3:0] count;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= 4'h0;
      end else if (clear && bump) begin
         count <= 4'h1;
      end else if (clear) begin
         count <= 4'h0;
      end else if (bump && count != 4'hF) begin
         count <= count + 4'h1;
      end
   end

   // Read straight off the count: LIMIT-1 resends, then give up
   always @* begin
      exhausted = (count >= LAST);
   end
endmodule // retry_counter

`default_nettype wire

// file: verif/initiator_model.sv
/* Initiator model: hands message bytes to the target with attention.
   Assumes tasks are called from one bench process. */
`timescale 1ns/1ps
`default_nettype none
module initiator_model (
   input wire logic clk,
   output logic msg_valid,
   output logic [7:0] msg_byte,
   output logic msg_parity_bad,
   output logic atn_pin
);
   // ---------
   // Transfers
   // ---------
   initial begin
      msg_valid = 1'b0;
      msg_byte = 8'h00;
      msg_parity_bad = 1'b0;
      atn_pin = 1'b0;
   end
   task automatic send(input logic [7:0] b, input logic bad);
      @(negedge clk);
      atn_pin = 1'b1;
      // Lead covers the target's attention synchroniser lag
      repeat (5) @(negedge clk);
      msg_valid = 1'b1;
      msg_byte = b;
      msg_parity_bad = bad;
      @(negedge clk);
      msg_valid = 1'b0;
      // Released lines must not keep the old byte
      msg_byte = ~b;
      msg_parity_bad = 1'b0;
      if (!bad) begin
         atn_pin = 1'b0;
      end
   endtask
   // Bad byte holds attention until the bench lets go
   task automatic drop_atn();
      @(negedge clk);
      atn_pin = 1'b0;
   endtask
endmodule // initiator_model
`default_nettype wire

// file: verif/msg_handler_sva.sv
/* Port checker for the message handler.
   Assumes a bind from the bench top and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "msg_consts.vh"
module msg_handler_sva #(
   parameter RETRY_LIMIT = 3
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic msg_valid,
   input wire logic [7:0] msg_byte,
   input wire logic msg_parity_bad,
   input wire logic parity_enable,
   input wire logic [2:0] phase,
   input wire logic cmd_complete_done,
   input wire logic [3:0] action,
   input wire logic action_valid,
   input wire logic [7:0] out_msg,
   input wire logic busy_release,
   input wire logic [3:0] sense_key,
   input wire logic [7:0] sense_code,
   input wire logic sense_valid,
   input wire logic clear_pending,
   input wire logic await_atn_drop
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire logic clean;
   assign clean = msg_valid && !msg_parity_bad;
   property p_abort;
      clean && msg_byte == `MSG_ABORT |=> action_valid &&
         action == `ACT_BUS_FREE && busy_release && clear_pending;
   endproperty
   property p_nop;
      clean && msg_byte == `MSG_NOP |=> !action_valid [*4];
   endproperty
   property p_unsup;
      clean && msg_byte == `MSG_EXTENDED |-> ##2 action_valid &&
         action == `ACT_SEND_MSG && out_msg == `MSG_REJECT;
   endproperty
   property p_err_in;
      clean && msg_byte == `MSG_INIT_ERR && phase == `PH_DATA_IN |=>
         action_valid && action == `ACT_CHECK_COND ##[0:1] sense_valid &&
         sense_key == `SENSE_KEY_ABORTED &&
         sense_code == `SENSE_CODE_INIT_ERR;
   endproperty
   property p_err_st;
      clean && msg_byte == `MSG_INIT_ERR &&
         (phase == `PH_STATUS || phase == `PH_MSG_IN) |=> action_valid &&
         action == `ACT_SEND_MSG && out_msg == `MSG_RESTORE_PTR;
   endproperty
   property p_devrst;
      clean && msg_byte == `MSG_DEV_RESET |=> clear_pending && busy_release;
   endproperty
   property p_done;
      cmd_complete_done |=> busy_release;
   endproperty
   property p_drain;
      msg_valid && msg_parity_bad && parity_enable &&
         phase == `PH_MSG_OUT |-> ##[1:2] await_atn_drop;
   endproperty
   property p_pulse;
      action_valid |=> !action_valid;
   endproperty
   a_abort: assert property (p_abort) else $error("abort");
   a_nop: assert property (p_nop) else $error("nop");
   a_unsup: assert property (p_unsup) else $error("unsup");
   a_err_in: assert property (p_err_in) else $error("err in");
   a_err_st: assert property (p_err_st) else $error("err st");
   a_devrst: assert property (p_devrst) else $error("devrst");
   a_done: assert property (p_done) else $error("done");
   a_drain: assert property (p_drain) else $error("drain");
   a_pulse: assert property (p_pulse) else $error("pulse");
   c_abort: cover property (busy_release && clear_pending);
   c_resend: cover property (action_valid && action == `ACT_RESEND_OUT);
   c_parity: cover property (sense_code == `SENSE_CODE_PARITY);
endmodule // msg_handler_sva
`default_nettype wire

// file: verif/scsi_target_message_handler_tb.sv
/* Bench for the message handler: initiator model, checker bind,
   directed and random messages.
   Assumes the constants header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "msg_consts.vh"
module scsi_target_message_handler_tb;
   // ------
   // Bench
   // ------
   localparam LIMIT = 3;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic parity_enable = 1'b1;
   logic [2:0] phase = `PH_MSG_OUT;
   logic [7:0] last_sent = `MSG_CMD_COMPLETE;
   logic reconnecting = 1'b0;
   logic cmd_complete_done = 1'b0;
   wire logic msg_valid, msg_parity_bad, atn_pin, action_valid;
   wire logic busy_release, sense_valid, disc_allowed, lun_valid;
   wire logic clear_pending, await_atn_drop;
   wire logic [7:0] msg_byte, out_msg, sense_code;
   wire logic [3:0] action, sense_key;
   wire logic [2:0] lun;
   int error_cnt = 0;
   int comparisons = 0;
   int seed = 29;
   logic [3:0] c_act;
   logic [7:0] c_msg, b;
   logic c_busy, c_clr;
   logic [7:0] sent_tab [6] = '{`MSG_CMD_COMPLETE, `MSG_DISCONNECT,
      `MSG_SAVE_PTR, `MSG_RESTORE_PTR, `MSG_IDENTIFY, `MSG_REJECT};
   always #5 clk = ~clk;
   initiator_model u_initiator_model (.clk(clk), .msg_valid(msg_valid),
      .msg_byte(msg_byte), .msg_parity_bad(msg_parity_bad),
      .atn_pin(atn_pin));
   msg_handler #(.RETRY_LIMIT(LIMIT)) u_msg_handler (.clk(clk),
      .reset(reset), .msg_valid(msg_valid), .msg_byte(msg_byte),
      .msg_parity_bad(msg_parity_bad), .atn_pin(atn_pin),
      .parity_enable(parity_enable), .phase(phase), .last_sent(last_sent),
      .reconnecting(reconnecting), .cmd_complete_done(cmd_complete_done),
      .msg_in_sent(1'b0), .action(action), .action_valid(action_valid),
      .out_msg(out_msg), .busy_release(busy_release),
      .sense_key(sense_key), .sense_code(sense_code),
      .sense_valid(sense_valid), .disc_allowed(disc_allowed), .lun(lun),
      .lun_valid(lun_valid), .clear_pending(clear_pending),
      .await_atn_drop(await_atn_drop));
   task end_of_test();
      $display("Counts: %0d compared, %0d wrong", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task miss(input string s);
      error_cnt++;
      $display("[FAIL] %0t %s", $time, s);
   endtask
   task chk_act(input logic [3:0] a, input logic [7:0] m);
      comparisons++;
      if (c_act !== a || (a == `ACT_SEND_MSG && c_msg !== m)) miss("action");
   endtask
   task chk_sense(input logic [3:0] k, input logic [7:0] c);
      @(negedge clk);
      comparisons++;
      if (sense_valid !== 1'b1 || sense_key !== k || sense_code !== c)
         miss("sense");
   endtask
   task chk_bit(input logic g, input logic e);
      comparisons++;
      if (g !== e) miss("flag");
   endtask
   // Bounded wait; a missing answer ends the run
   task wait_act();
      for (int i = 0; i < 12; i++) begin
         if (action_valid === 1'b1) begin
            c_act = action;
            c_msg = out_msg;
            c_busy = busy_release;
            c_clr = clear_pending;
            return;
         end
         @(negedge clk);
      end
      miss("no action");
      end_of_test();
   endtask
   task quiet(input int n);
      repeat (n) begin
         @(negedge clk);
         chk_bit(action_valid, 1'b0);
      end
   endtask
   // ---------
   // Sequence
   // ---------
   initial begin
      repeat (5) @(negedge clk);
      reset = 1'b0;
      u_initiator_model.send(`MSG_ABORT, 1'b0);
      wait_act();
      chk_act(`ACT_BUS_FREE, 8'h00);
      chk_bit(c_busy & c_clr, 1'b1);
      u_initiator_model.send(`MSG_NOP, 1'b0);
      quiet(6);
      for (int i = 0; i < 3; i++) begin
         phase = (i == 0) ? `PH_STATUS : (i == 1) ? `PH_MSG_IN : `PH_DATA_IN;
         u_initiator_model.send(`MSG_INIT_ERR, 1'b0);
         wait_act();
         if (i < 2) chk_act(`ACT_SEND_MSG, `MSG_RESTORE_PTR);
      end
      chk_act(`ACT_CHECK_COND, 8'h00);
      chk_sense(`SENSE_KEY_ABORTED, `SENSE_CODE_INIT_ERR);
      phase = `PH_MSG_OUT;
      for (int i = 0; i < 2; i++) begin
         u_initiator_model.send(i ? `MSG_CMD_COMPLETE : `MSG_EXTENDED, 1'b0);
         wait_act();
         chk_act(`ACT_SEND_MSG, `MSG_REJECT);
      end
      $display("Test basic done");
      for (int i = 0; i < LIMIT; i++) begin
         u_initiator_model.send(`MSG_NOP, 1'b1);
         @(negedge clk);
         chk_bit(await_atn_drop, 1'b1);
         u_initiator_model.drop_atn();
         wait_act();
         if (i < LIMIT - 1) chk_act(`ACT_RESEND_OUT, 8'h00);
         else chk_sense(`SENSE_KEY_ABORTED, `SENSE_CODE_PARITY);
      end
      u_initiator_model.send(`MSG_DEV_RESET, 1'b0);
      wait_act();
      chk_bit(c_busy & c_clr, 1'b1);
      @(negedge clk);
      chk_bit(sense_valid | lun_valid | disc_allowed, 1'b0);
      cmd_complete_done = 1'b1;
      @(negedge clk);
      cmd_complete_done = 1'b0;
      chk_bit(busy_release, 1'b1);
      $display("Test out parity and reset done");
      for (int i = 0; i < 12; i++) begin
         b = (i == 0) ? 8'hC3 : (i == 1) ? 8'h84 : 8'($random(seed));
         b[7] = 1'b1;
         u_initiator_model.send(b, 1'b0);
         wait_act();
         if (b[5:3] == 3'h0 && b[2:0] <= `ID_LUN_MAX) begin
            chk_act(`ACT_IDENT_OK, 8'h00);
            chk_bit(lun_valid === 1'b1 && lun === b[2:0], 1'b1);
            chk_bit(disc_allowed, b[6]);
         end else begin
            chk_act(`ACT_SEND_MSG, `MSG_REJECT);
         end
      end
      for (int i = 0; i < 6; i++) begin
         last_sent = sent_tab[i];
         reconnecting = (i == 4);
         u_initiator_model.send(`MSG_REJECT, 1'b0);
         wait_act();
         if (i == 0 || i > 3) chk_act(`ACT_BUS_FREE, 8'h00);
         if (i == 0) chk_bit(c_busy & ~sense_valid, 1'b1);
         else if (i < 3) chk_act(`ACT_STOP_DISC, 8'h00);
         else if (i == 3) chk_act(`ACT_STOP_RETRY, 8'h00);
         else chk_sense(`SENSE_KEY_ABORTED, `SENSE_CODE_REJECT);
      end
      reconnecting = 1'b0;
      $display("Test identify and rejects done");
      parity_enable = 1'b0;
      u_initiator_model.send(`MSG_PARITY_ERR, 1'b0);
      wait_act();
      chk_act(`ACT_SEND_MSG, `MSG_REJECT);
      u_initiator_model.send(`MSG_NOP, 1'b1);
      quiet(6);
      chk_bit(await_atn_drop, 1'b0);
      u_initiator_model.drop_atn();
      parity_enable = 1'b1;
      last_sent = `MSG_SAVE_PTR;
      u_initiator_model.send(`MSG_PARITY_ERR, 1'b0);
      wait_act();
      chk_act(`ACT_SEND_MSG, `MSG_SAVE_PTR);
      last_sent = `MSG_DISCONNECT;
      for (int i = 0; i < LIMIT; i++) begin
         u_initiator_model.send(`MSG_PARITY_ERR, 1'b0);
         wait_act();
         if (i < LIMIT - 1) chk_act(`ACT_SEND_MSG, `MSG_DISCONNECT);
         else chk_sense(`SENSE_KEY_ABORTED, `SENSE_CODE_PARITY);
      end
      $display("Test in parity done");
      end_of_test();
   end
endmodule // scsi_target_message_handler_tb
bind msg_handler msg_handler_sva #(.RETRY_LIMIT(RETRY_LIMIT)) u_sva (
   .clk(clk), .reset(reset), .msg_valid(msg_valid), .msg_byte(msg_byte),
   .msg_parity_bad(msg_parity_bad), .parity_enable(parity_enable),
   .phase(phase), .cmd_complete_done(cmd_complete_done), .action(action),
   .action_valid(action_valid), .out_msg(out_msg),
   .busy_release(busy_release), .sense_key(sense_key),
   .sense_code(sense_code), .sense_valid(sense_valid),
   .clear_pending(clear_pending), .await_atn_drop(await_atn_drop));
`default_nettype wire
